// ---- design/als_map.svh ----
`ifndef ALS_MAP_SVH
`define ALS_MAP_SVH
// ****************************************
// clock and timing figures, in their own units
// ****************************************
`define ALS_CLK_HZ        250000000
`define ALS_POL_FILT_US   200
`define ALS_FREQ_MAX_HZ   72
`define ALS_FREQ_MIN_HZ   42
`define ALS_FREQ_DLY_MS   100
`define ALS_DIP_MS        25
`define ALS_SHUTDOWN_MS   650
`define ALS_HIGH_QUAL_US  300
`define ALS_LOW_QUAL_MS   25
`define ALS_LOCKOUT_MS    500
`define ALS_EDGES_NEEDED  3'h4
// ****************************************
// register offsets, fields and reset values
// ****************************************
`define ALS_CTRL_OFF      8'h00
`define ALS_STATUS_OFF    8'h04
`define ALS_INTERVAL_OFF  8'h08
`define ALS_CTRL_MON_BIT  0
`define ALS_CTRL_RST      1'b1
`define ALS_HIGH_GAIN_SHIFT 2'h2
`define ALS_LOW_GAIN_SHIFT  2'h0
`endif

// ---- design/als_pkg.sv ----
package als_pkg;
   // decisions of the analog line-sense comparators
   typedef struct packed {
      logic above_start;   // line above undervoltage start threshold
      logic below_stop;    // line below undervoltage stop threshold
      logic above_high;    // line above high range threshold
      logic below_low;     // line below low range threshold
   } als_line_cmp_t;

   typedef enum logic [1:0] {
      RANGE_LOW  = 2'b01,
      RANGE_HIGH = 2'b10
   } als_range_t;
endpackage

// ---- design/als_line_supervisor.sv ----
`timescale 1ns/1ns
`include "als_map.svh"
module als_line_supervisor #(
   parameter int unsigned CLK_HZ    = `ALS_CLK_HZ,
   parameter int unsigned POL_CYC   = (CLK_HZ / 1000000) * `ALS_POL_FILT_US,
   parameter int unsigned WIN_MIN   = CLK_HZ / (2 * `ALS_FREQ_MAX_HZ),
   parameter int unsigned WIN_MAX   = CLK_HZ / (2 * `ALS_FREQ_MIN_HZ),
   parameter int unsigned FDLY_CYC  = (CLK_HZ / 1000) * `ALS_FREQ_DLY_MS,
   parameter int unsigned DIP_CYC   = (CLK_HZ / 1000) * `ALS_DIP_MS,
   parameter int unsigned BO_CYC    = (CLK_HZ / 1000) * `ALS_SHUTDOWN_MS,
   parameter int unsigned HIGH_CYC  = (CLK_HZ / 1000000) * `ALS_HIGH_QUAL_US,
   parameter int unsigned LOW_CYC   = (CLK_HZ / 1000) * `ALS_LOW_QUAL_MS,
   parameter int unsigned LOCK_CYC  = (CLK_HZ / 1000) * `ALS_LOCKOUT_MS,
   parameter logic [2:0]  EDGES     = `ALS_EDGES_NEEDED
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  resetn,
   // analog front end, asynchronous
   input  wire logic                  polarity_raw,
   input  wire als_pkg::als_line_cmp_t line_cmp,
   input  wire logic                  supply_ok,
   // drive and compensator control
   output logic                       fast_leg_enable,
   output logic                       slow_leg_low_drive,
   output logic                       slow_leg_high_drive,
   output logic                       soft_stop,
   output logic                       polarity_filtered,
   output logic                       polarity_detect_en,
   output logic                       line_freq_valid,
   output logic                       freq_fault,
   output logic                       high_line_mode,
   output logic [1:0]                 loop_gain_shift,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata
);
   if (WIN_MIN == 0 || WIN_MIN >= WIN_MAX || EDGES == 3'h0 ||
       POL_CYC == 0 || FDLY_CYC == 0 || DIP_CYC == 0 ||
       BO_CYC == 0 || HIGH_CYC == 0 || LOW_CYC == 0) begin : g_chk
      $error("als_line_supervisor: bad timing parameters");
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   logic                    pol_m, pol_s, sup_m, sup_s;
   als_pkg::als_line_cmp_t  cmp_m, cmp_s;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         {pol_m, pol_s, sup_m, sup_s} <= 4'h0;
         {cmp_m, cmp_s}               <= 8'h00;
      end else begin
         {pol_s, pol_m} <= {pol_m, polarity_raw};
         {sup_s, sup_m} <= {sup_m, supply_ok};
         {cmp_s, cmp_m} <= {cmp_m, line_cmp};
      end
   end
   logic        shutdown;
   logic        core_clr;
   logic        mon_en;
   assign core_clr = !resetn || shutdown;

   // ****************************************
   // polarity deglitch
   // ****************************************
   logic [31:0] pol_cnt;
   logic        pol_filt, pol_prev;
   always_ff @(posedge clock) begin
      if (core_clr) begin
         pol_cnt  <= 32'h0;
         pol_filt <= 1'b0;
      end else if (pol_s == pol_filt) begin
         pol_cnt  <= 32'h0;
      end else if (pol_cnt == POL_CYC) begin
         // new level held longer than the qualification time
         pol_filt <= pol_s;
         pol_cnt  <= 32'h0;
      end else begin
         pol_cnt  <= pol_cnt + 32'h1;
      end
   end
   always_ff @(posedge clock) begin
      if (core_clr) pol_prev <= 1'b0;
      else          pol_prev <= pol_filt;
   end
   logic edge_ev, rise_ev;
   assign edge_ev = pol_filt ^ pol_prev;
   assign rise_ev = pol_filt & !pol_prev;

   // ****************************************
   // edge interval measurement
   // ****************************************
   logic [31:0] iv_cnt, last_iv;
   logic        seen_edge;
   logic        in_range, in_win, out_ev;
   // the counter saturates one past the window so a lost line
   // raises exactly one out-of-window event
   always_ff @(posedge clock) begin
      if (core_clr) begin
         iv_cnt    <= 32'h0;
         last_iv   <= 32'h0;
         seen_edge <= 1'b0;
      end else if (edge_ev) begin
         iv_cnt    <= 32'h1;
         last_iv   <= iv_cnt;
         seen_edge <= 1'b1;
      end else if (iv_cnt <= WIN_MAX) begin
         iv_cnt    <= iv_cnt + 32'h1;
      end
   end
   assign in_range = iv_cnt >= WIN_MIN && iv_cnt <= WIN_MAX;
   assign in_win   = edge_ev && seen_edge && (in_range || !mon_en);
   assign out_ev   = mon_en && seen_edge &&
                     (edge_ev ? !in_range : iv_cnt == WIN_MAX);

   // ****************************************
   // valid edge count, frequency fault
   // ****************************************
   logic [2:0]  valid_edge_count;
   logic        slow_off, dly_run, started;
   logic [31:0] dly_cnt;
   logic        start_ev, fault_exit;
   assign fault_exit = in_win && valid_edge_count == EDGES - 3'h1;
   assign start_ev   = rise_ev && in_win &&
                       valid_edge_count >= EDGES - 3'h1;
   always_ff @(posedge clock) begin
      if (core_clr)
         valid_edge_count <= 3'h0;
      else if (out_ev)
         valid_edge_count <= 3'h0;
      else if (in_win && valid_edge_count < EDGES)
         valid_edge_count <= valid_edge_count + 3'h1;
   end
   always_ff @(posedge clock) begin
      if (core_clr) begin
         slow_off   <= 1'b0;
         dly_run    <= 1'b0;
         dly_cnt    <= 32'h0;
         freq_fault <= 1'b0;
      end else if (out_ev) begin
         slow_off <= 1'b1;
         if (!dly_run && !freq_fault) begin
            dly_run <= 1'b1;
            dly_cnt <= 32'h0;
         end
      end else if (in_win && (!freq_fault || fault_exit)) begin
         // a good interval beats a timer expiring in the same cycle
         slow_off   <= 1'b0;
         dly_run    <= 1'b0;
         freq_fault <= 1'b0;
      end else if (dly_run) begin
         if (dly_cnt == FDLY_CYC - 1) begin
            freq_fault <= 1'b1;
            dly_run    <= 1'b0;
         end else begin
            dly_cnt <= dly_cnt + 32'h1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (core_clr)
         line_freq_valid <= 1'b0;
      else if (out_ev)
         line_freq_valid <= 1'b0;
      else if (start_ev)
         line_freq_valid <= 1'b1;
   end

   // ****************************************
   // undervoltage: dip and shutdown timers
   // ****************************************
   logic        uv_flag;
   logic [31:0] dip_cnt, bo_cnt;
   // not cleared by the shutdown itself: it must see the line return
   always_ff @(posedge clock) begin
      if (!resetn) begin
         uv_flag   <= 1'b1;
         soft_stop <= 1'b0;
         shutdown  <= 1'b0;
         dip_cnt   <= 32'h0;
         bo_cnt    <= 32'h0;
      end else if (cmp_s.above_start) begin
         uv_flag   <= 1'b0;
         soft_stop <= 1'b0;
         shutdown  <= 1'b0;
         dip_cnt   <= 32'h0;
         bo_cnt    <= 32'h0;
      end else if (cmp_s.below_stop) begin
         if (dip_cnt == DIP_CYC - 1) begin
            soft_stop <= 1'b1;
            uv_flag   <= 1'b1;
         end else begin
            dip_cnt <= dip_cnt + 32'h1;
         end
         if (bo_cnt == BO_CYC - 1)
            shutdown <= 1'b1;
         else
            bo_cnt <= bo_cnt + 32'h1;
      end else begin
         dip_cnt <= 32'h0;
         bo_cnt  <= 32'h0;
      end
   end

   // ****************************************
   // startup and drive enables
   // ****************************************
   always_ff @(posedge clock) begin
      if (core_clr)
         started <= 1'b0;
      else if (freq_fault || soft_stop || uv_flag)
         started <= 1'b0;
      else if (start_ev && sup_s)
         started <= 1'b1;
   end
   logic next_fast, next_slow;
   assign next_fast = started && !uv_flag && !soft_stop &&
                      !freq_fault && !shutdown;
   assign next_slow = next_fast && !slow_off;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         {fast_leg_enable, slow_leg_low_drive, slow_leg_high_drive,
          polarity_filtered, polarity_detect_en} <= 5'h00;
      end else begin
         fast_leg_enable     <= next_fast;
         slow_leg_low_drive  <= next_slow && pol_filt;
         slow_leg_high_drive <= next_slow && !pol_filt;
         polarity_filtered   <= pol_filt;
         polarity_detect_en  <= !shutdown;
      end
   end

   // ****************************************
   // line range detection
   // ****************************************
   als_pkg::als_range_t range;
   logic [31:0]         hi_cnt, lo_cnt, lock_cnt;
   always_ff @(posedge clock) begin
      if (core_clr) begin
         range    <= als_pkg::RANGE_LOW;
         hi_cnt   <= 32'h0;
         lo_cnt   <= 32'h0;
         lock_cnt <= 32'h0;
      end else begin
         if (lock_cnt != 32'h0)
            lock_cnt <= lock_cnt - 32'h1;
         unique case (range)
            als_pkg::RANGE_LOW: begin
               lo_cnt <= 32'h0;
               if (!cmp_s.above_high)
                  hi_cnt <= 32'h0;
               else if (hi_cnt == HIGH_CYC && lock_cnt == 32'h0) begin
                  range  <= als_pkg::RANGE_HIGH;
                  hi_cnt <= 32'h0;
               end else if (hi_cnt != HIGH_CYC)
                  hi_cnt <= hi_cnt + 32'h1;
            end
            als_pkg::RANGE_HIGH: begin
               hi_cnt <= 32'h0;
               if (!cmp_s.below_low)
                  lo_cnt <= 32'h0;
               else if (lo_cnt == LOW_CYC) begin
                  range    <= als_pkg::RANGE_LOW;
                  lo_cnt   <= 32'h0;
                  lock_cnt <= LOCK_CYC;
               end else
                  lo_cnt <= lo_cnt + 32'h1;
            end
            default: range <= als_pkg::RANGE_LOW;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         high_line_mode  <= 1'b0;
         loop_gain_shift <= `ALS_LOW_GAIN_SHIFT;
      end else begin
         high_line_mode  <= range == als_pkg::RANGE_HIGH;
         // shift of two divides the compensator gain by four
         loop_gain_shift <= range == als_pkg::RANGE_HIGH ?
                            `ALS_HIGH_GAIN_SHIFT :
                            `ALS_LOW_GAIN_SHIFT;
      end
   end

   // ****************************************
   // AHB-Lite register slave, zero wait states
   // ****************************************
   logic       wr_pend;
   logic [7:0] wr_off;
   logic       take;
   assign take      = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_pend <= 1'b0;
         wr_off  <= 8'h00;
         hrdata  <= 32'h0;
         mon_en  <= `ALS_CTRL_RST;
      end else begin
         wr_pend <= take && hwrite;
         wr_off  <= haddr[7:0];
         if (wr_pend && wr_off == `ALS_CTRL_OFF)
            mon_en <= hwdata[`ALS_CTRL_MON_BIT];
         if (take && !hwrite) begin
            unique case (haddr[7:0])
               `ALS_CTRL_OFF:     hrdata <= {31'h0, mon_en};
               `ALS_STATUS_OFF:   hrdata <= {21'h0, valid_edge_count,
                  high_line_mode, shutdown, soft_stop, uv_flag,
                  freq_fault, line_freq_valid, started, pol_filt};
               `ALS_INTERVAL_OFF: hrdata <= last_iv;
               default:           hrdata <= 32'h0;
            endcase
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_bad_interval;
      out_ev && !freq_fault;
   endsequence
   sequence s_slow_dropped;
      ##2 (!slow_leg_low_drive && !slow_leg_high_drive);
   endsequence

   filt_qualify_a: assert property ($changed(pol_filt) && !shutdown
      |-> $past(pol_cnt) == POL_CYC)
      else $error("polarity changed without full qualification");
   filt_restart_a: assert property (pol_s == pol_filt && !shutdown
      |=> pol_cnt == 32'h0 && $stable(pol_filt))
      else $error("deglitch timer not restarted");
   interval_take_a: assert property (edge_ev && !shutdown
      |=> last_iv == $past(iv_cnt) && iv_cnt == 32'h1)
      else $error("edge interval not captured");
   slow_drop_a: assert property (s_bad_interval |-> s_slow_dropped
      or (##1 shutdown))
      else $error("slow legs not dropped on bad interval");
   good_clear_a: assert property (in_win && !freq_fault && !out_ev
      && !shutdown |=> !slow_off && !dly_run)
      else $error("good interval did not clear delay");
   fault_enter_a: assert property ($rose(freq_fault)
      |-> $past(dly_cnt) == FDLY_CYC - 1 ##1 !fast_leg_enable)
      else $error("fault entered without delay expiry");
   fault_exit_a: assert property ($fell(freq_fault) && !$past(shutdown)
      |-> valid_edge_count == EDGES)
      else $error("fault left before enough good edges");
   valid_rise_a: assert property ($rose(line_freq_valid)
      |-> $past(rise_ev) && $past(in_win))
      else $error("valid flag set off a rising edge");
   dip_soft_a: assert property ($rose(soft_stop)
      |-> $past(dip_cnt) == DIP_CYC - 1 ##1 !fast_leg_enable)
      else $error("soft stop without dip expiry");
   high_enter_a: assert property ($rose(range == als_pkg::RANGE_HIGH)
      |-> $past(hi_cnt) == HIGH_CYC && $past(lock_cnt) == 32'h0)
      else $error("high line entered early or in lockout");
   lockout_start_a: assert property ($fell(range == als_pkg::RANGE_HIGH)
      && !$past(shutdown) |-> lock_cnt == LOCK_CYC)
      else $error("lockout not started on high to low");

endmodule // als_line_supervisor

// ---- verif/als_line_model.sv ----
`timescale 1ns/1ns
// ****************************************
// line-sense comparators and polarity source
// ****************************************
module als_line_model (
   // clock
   input  wire logic                   clock,
   // stimulus control
   input  wire logic                   run,
   input  wire logic [15:0]            half_cyc,
   input  wire logic                   raw_in,
   input  wire logic [1:0]             level,
   // comparator decisions
   output logic                        polarity_raw,
   output als_pkg::als_line_cmp_t      line_cmp
);
   logic [15:0] cnt;
   logic        pol;

   // free square wave while running, else the bench's raw level
   always_ff @(posedge clock) begin
      if (!run) begin
         cnt <= 16'h0000;
         pol <= raw_in;
      end else if (cnt + 16'h0001 >= half_cyc) begin
         cnt <= 16'h0000;
         pol <= ~pol;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   assign polarity_raw = pol;

   // level 0 dip, 1 low line, 2 high line
   always_comb begin
      case (level)
         2'h0:    line_cmp = 4'b0101;
         2'h2:    line_cmp = 4'b1010;
         default: line_cmp = 4'b1001;
      endcase
   end
endmodule // als_line_model

// ---- verif/als_line_supervisor_tb.sv ----
`timescale 1ns/1ns
module als_line_supervisor_tb;
   // ****************************************
   // stimulus and wiring
   // ****************************************
   logic        clock     = 1'b0;
   logic        resetn    = 1'b0;
   logic        run       = 1'b0;
   logic        raw_in    = 1'b0;
   logic [1:0]  level     = 2'h1;
   logic [15:0] half_cyc  = 16'h003C;
   logic        supply_ok = 1'b0;
   logic        hsel      = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'b0;
   logic [2:0]  hsize     = 3'h2;
   logic [31:0] hwdata    = 32'h0;
   logic        polarity_raw, fast_leg_enable, slow_lo, slow_hi, soft_stop;
   logic        pol_filt, detect_en, freq_valid, freq_fault, high_line;
   logic        hreadyout, hresp;
   logic [1:0]  gain_shift;
   logic [31:0] hrdata, rd, d;
   als_pkg::als_line_cmp_t line_cmp;
   int          fails      = 0;
   int          num_checks = 0;
   logic [15:0] h;

   always #2 clock = ~clock;

   als_line_model als_line_model_i (.clock(clock), .run(run),
      .half_cyc(half_cyc), .raw_in(raw_in), .level(level),
      .polarity_raw(polarity_raw), .line_cmp(line_cmp));

   // a slow nominal clock scales the millisecond timers down: fault delay 800,
   // dip and low-line 200, shutdown 5200, lockout 4000 cycles
   als_line_supervisor #(.CLK_HZ(8000), .POL_CYC(8), .WIN_MIN(40),
      .WIN_MAX(80), .HIGH_CYC(10)) als_line_supervisor_i (
      .clock(clock), .resetn(resetn), .polarity_raw(polarity_raw),
      .line_cmp(line_cmp), .supply_ok(supply_ok),
      .fast_leg_enable(fast_leg_enable), .slow_leg_low_drive(slow_lo),
      .slow_leg_high_drive(slow_hi), .soft_stop(soft_stop),
      .polarity_filtered(pol_filt), .polarity_detect_en(detect_en),
      .line_freq_valid(freq_valid), .freq_fault(freq_fault),
      .high_line_mode(high_line), .loop_gain_shift(gain_shift),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0:       return fast_leg_enable;
         1:       return slow_lo | slow_hi;
         2:       return freq_fault;
         3:       return freq_valid;
         4:       return soft_stop;
         5:       return detect_en;
         default: return high_line;
      endcase
   endfunction

   // bounded wait for a level, then compare it
   task automatic wait_for(input string what, input int s, input logic v,
                           input int lim);
      int n;
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(posedge clock);
         n++;
      end
      check(what, {31'h0, v}, {31'h0, pick(s)});
   endtask

   // single AHB-Lite transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      q = hrdata;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      void'($urandom(32'h49D1));
      cyc(6);
      resetn <= 1'b1;
      cyc(1);
      check("fast_leg_enable", 32'h0, {31'h0, fast_leg_enable});
      check("high_line_mode", 32'h0, {31'h0, high_line});
      check("loop_gain_shift", 32'h0, {30'h0, gain_shift});
      bus(1'b0, 32'h0, 32'h0, rd);
      check("ctrl", 32'h1, rd & 32'h1);
      bus(1'b0, 32'h3C, 32'h0, rd);
      check("unmapped", 32'h0, rd);
      $display("test reset done");

      repeat (4) begin
         raw_in <= 1'b1;
         cyc(1 + $urandom_range(5));
         raw_in <= 1'b0;
         cyc(4);
      end
      cyc(10);
      check("glitch", 32'h0, {31'h0, pol_filt});
      raw_in <= 1'b1;
      cyc(8);
      check("early", 32'h0, {31'h0, pol_filt});
      cyc(8);
      check("qualified", 32'h1, {31'h0, pol_filt});
      $display("test deglitch done");

      level <= 2'h2;
      cyc(8);
      check("high_line early", 32'h0, {31'h0, high_line});
      wait_for("high_line", 6, 1'b1, 30);
      check("gain high", 32'h2, {30'h0, gain_shift});
      level <= 2'h1;
      cyc(150);
      check("high_line held", 32'h1, {31'h0, high_line});
      wait_for("low_line", 6, 1'b0, 100);
      check("gain low", 32'h0, {30'h0, gain_shift});
      level <= 2'h2;
      cyc(2000);
      check("lockout", 32'h0, {31'h0, high_line});
      wait_for("after lockout", 6, 1'b1, 2500);
      level <= 2'h1;
      cyc(250);
      $display("test range done");

      h = 16'(50 + $urandom_range(20));
      half_cyc <= h;
      run <= 1'b1;
      cyc(800);
      check("no supply", 32'h0, {31'h0, fast_leg_enable});
      supply_ok <= 1'b1;
      wait_for("start", 0, 1'b1, 300);
      check("rising start", 32'h1, {31'h0, pol_filt});
      bus(1'b0, 32'h4, 32'h0, rd);
      check("valid flag", 32'h4, rd & 32'h4);
      bus(1'b0, 32'h8, 32'h0, rd);
      check("interval", 32'h1, {31'h0, rd >= h - 1 && rd <= h + 1});
      $display("test startup done");

      half_cyc <= 16'h0078;
      wait_for("slow off", 1, 1'b0, 300);
      check("fast kept", 32'h1, {31'h0, fast_leg_enable});
      half_cyc <= h;
      wait_for("slow back", 1, 1'b1, 400);
      check("no fault", 32'h0, {31'h0, freq_fault});
      half_cyc <= 16'h0078;
      wait_for("slow off", 1, 1'b0, 300);
      cyc(700);
      check("delay running", 32'h0, {31'h0, freq_fault});
      wait_for("fault", 2, 1'b1, 200);
      // the enables register one edge after the fault flag
      cyc(1);
      check("fast off", 32'h0, {31'h0, fast_leg_enable});
      check("slow off", 32'h0, {31'h0, slow_lo | slow_hi});
      half_cyc <= h;
      wait_for("fault exit", 2, 1'b0, 800);
      wait_for("restart", 0, 1'b1, 400);
      $display("test frequency done");

      d = $urandom & 32'hFFFF_FFFE;
      bus(1'b1, 32'h0, d, rd);
      half_cyc <= 16'h0078;
      cyc(1000);
      check("monitor off", 32'h0, {31'h0, freq_fault});
      check("monitor slow", 32'h1, {31'h0, slow_lo | slow_hi});
      bus(1'b1, 32'h0, 32'h1, rd);
      half_cyc <= h;
      cyc(400);
      $display("test monitor done");

      level <= 2'h0;
      cyc(150);
      check("dip drive", 32'h1, {31'h0, fast_leg_enable});
      wait_for("soft stop", 4, 1'b1, 150);
      check("detect on", 32'h1, {31'h0, detect_en});
      level <= 2'h1;
      wait_for("soft end", 4, 1'b0, 20);
      wait_for("quick restart", 0, 1'b1, 300);
      level <= 2'h0;
      wait_for("soft stop", 4, 1'b1, 300);
      wait_for("shutdown", 5, 1'b0, 5300);
      check("range reset", 32'h0, {31'h0, high_line});
      check("off", 32'h0, {31'h0, fast_leg_enable});
      level <= 2'h1;
      wait_for("detect back", 5, 1'b1, 20);
      wait_for("power-up start", 0, 1'b1, 1500);
      $display("test undervoltage done");
      print_verdict();
   end

   // hang guard, well beyond the longest expected run
   initial begin
      cyc(40000);
      fails++;
      $display("Error watchdog expected finish seen timeout");
      print_verdict();
   end
endmodule // als_line_supervisor_tb
